// ==== verilog/fqt_pkg.sv ====
// query-table reader constants: commands, addresses, timing, expected table
// assumes a 10 MHz single clock and a parallel flash on the far side of the pins
// Functional notes
// - query entry: 98h at 55h word, AAh byte
// - word mode: address bits seven upward zero
// - reset command leaves query, back to array
// - entry also legal from identification state
`default_nettype none

package fqt_pkg;

	// ------------------------------------------------------------------
	// command bytes and addresses
	// ------------------------------------------------------------------
	localparam logic [7:0]  CMD_QUERY    = 8'h98;      // query entry byte
	localparam logic [7:0]  CMD_RESET    = 8'hF0;      // reset byte, plain default
	localparam logic [20:0] ADDR_QRY_W   = 21'h000055; // entry address, word mode
	localparam logic [20:0] ADDR_QRY_B   = 21'h0000AA; // entry address, byte mode
	localparam logic [20:0] ADDR_RESET   = 21'h000000; // reset address, any will do
	localparam logic [5:0]  IDX_FIRST    = 6'h10;      // first table word
	localparam logic [5:0]  IDX_LAST     = 6'h3C;      // last table word

	// ------------------------------------------------------------------
	// timing
	// ------------------------------------------------------------------
	localparam int          CLK_NS       = 100;        // sys_clk period
	localparam int          T_STROBE_NS  = 200;        // least strobe width
	localparam int          STROBE_CYC_I = (T_STROBE_NS + CLK_NS - 1) / CLK_NS;
	localparam logic [2:0]  STROBE_CYC   = 3'(STROBE_CYC_I < 1 ? 1 : STROBE_CYC_I);
	localparam logic [2:0]  SYNC_CYC     = 3'h3;       // pin synchroniser depth

	// ------------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------------
	localparam logic        STROBE_OFF   = 1'b1;       // active-low strobes idle high
	localparam logic [5:0]  CNT_RST      = 6'h00;      // counters clear
	localparam logic        BYTE_N_RST   = 1'b1;       // width pin: word mode after reset

	// ------------------------------------------------------------------
	// expected table contents, by word index
	// ------------------------------------------------------------------
	function automatic logic [15:0] fqt_expect(input logic [5:0] idx);
		logic [15:0] v;
		v = 16'h0000;                                // unlisted words read zero
		case (idx)
			6'h10: v = 16'h0051;
			6'h11: v = 16'h0052;
			6'h12: v = 16'h0059;
			6'h13: v = 16'h0002;
			6'h15: v = 16'h0040;
			6'h1B: v = 16'h0027;
			6'h1C: v = 16'h0036;
			6'h1F: v = 16'h0007;
			6'h21: v = 16'h000A;
			6'h23: v = 16'h0001;
			6'h25: v = 16'h0004;
			6'h27: v = 16'h0015;
			6'h28: v = 16'h0002;
			6'h2C: v = 16'h0004;
			6'h2F: v = 16'h0040;
			6'h31: v = 16'h0001;
			6'h33: v = 16'h0020;
			6'h37: v = 16'h0080;
			6'h39: v = 16'h001E;
			6'h3C: v = 16'h0001;
			default: v = 16'h0000;
		endcase
		return v;
	endfunction

	// word index to pin address, doubled in byte mode
	function automatic logic [20:0] fqt_map(input logic [5:0] idx, input logic byte_mode);
		logic [20:0] a;
		a = byte_mode ? {14'h0000, idx, 1'b0} : {15'h0000, idx};
		return a;
	endfunction

endpackage

`default_nettype wire

// ==== verilog/fqt_cyc_if.sv ====
// request/answer link between the sequencer and the bus cycle engine
// assumes both ends run on sys_clk
`default_nettype none

interface fqt_cyc_if;
	logic        req;    // one-cycle request pulse
	logic        is_wr;  // write cycle when high
	logic [20:0] addr;   // pin address
	logic [7:0]  wdata;  // command byte
	logic        ack;    // one-cycle completion pulse
	logic [15:0] rdata;  // captured read data, valid with ack

	modport seq (output req, output is_wr, output addr, output wdata, input ack, input rdata);
	modport eng (input req, input is_wr, input addr, input wdata, output ack, output rdata);
endinterface

`default_nettype wire

// ==== verilog/fqt_cycle.sv ====
// bus cycle engine: one write or read strobe on the flash pins per request
// assumes the flash data pins are asynchronous to sys_clk
`default_nettype none

module fqt_cycle
(
	input  wire logic        sys_clk,
	input  wire logic        srst,
	fqt_cyc_if.eng           cyc,
	output logic [20:0]      flash_addr,
	output logic [15:0]      flash_dq_o,
	output logic             flash_dq_oe,
	input  wire logic [15:0] flash_dq_i,
	output logic             flash_ce_n,
	output logic             flash_we_n,
	output logic             flash_oe_n
);

	// ------------------------------------------------------------------
	// state
	// ------------------------------------------------------------------
	typedef enum logic [2:0]
	{
		E_IDLE   = 3'h0,
		E_SETUP  = 3'h1,
		E_STROBE = 3'h3,
		E_SAMPLE = 3'h2,
		E_HOLD   = 3'h6
	} fqt_eng_st_t;

	typedef struct packed
	{
		fqt_eng_st_t st;     // cycle phase
		logic        wr;     // current cycle is a write
		logic [2:0]  cnt;    // phase counter
		logic [15:0] s1;     // first sync stage, read only by s2
		logic [15:0] s2;     // second sync stage
		logic [15:0] s3;     // third sync stage
		logic [20:0] addr;   // pin address
		logic [15:0] dq_o;   // pin data out
		logic        dq_oe;  // pin data enable
		logic        ce_n;   // chip select
		logic        we_n;   // write strobe
		logic        oe_n;   // read strobe
		logic        ack;    // completion pulse
		logic [15:0] rdata;  // captured data
	} fqt_eng_t;

	fqt_eng_t q;  // registered state
	fqt_eng_t d;  // next state

	// ------------------------------------------------------------------
	// next state
	// ------------------------------------------------------------------
	always_comb
	begin
		d     = q;
		d.ack = 1'b0;
		d.s1  = flash_dq_i;
		d.s2  = q.s1;
		d.s3  = q.s2;
		case (q.st)
			E_IDLE:
			begin
				// address and chip select first, strobe a cycle later
				if (cyc.req)
				begin
					d.addr  = cyc.addr;
					d.dq_o  = {8'h00, cyc.wdata};
					d.dq_oe = cyc.is_wr;
					d.wr    = cyc.is_wr;
					d.ce_n  = 1'b0;
					d.cnt   = 3'h0;
					d.st    = E_SETUP;
				end
			end
			E_SETUP:
			begin
				// strobe falls after chip select: its fall is the later one
				if (q.wr)
					d.we_n = 1'b0;
				else
					d.oe_n = 1'b0;
				d.st = E_STROBE;
			end
			E_STROBE:
			begin
				d.cnt = q.cnt + 3'h1;
				if (q.cnt == fqt_pkg::STROBE_CYC - 3'h1)
				begin
					d.cnt = 3'h0;
					if (q.wr)
					begin
						// strobe rises before chip select; data still driven
						d.we_n = 1'b1;
						d.st   = E_HOLD;
					end
					else
						d.st = E_SAMPLE;
				end
			end
			E_SAMPLE:
			begin
				// wait out the synchroniser, then take data once stages agree
				if (q.cnt < fqt_pkg::SYNC_CYC)
					d.cnt = q.cnt + 3'h1;
				else if (q.s2 == q.s3)
				begin
					d.rdata = q.s3;
					d.oe_n  = 1'b1;
					d.st    = E_HOLD;
				end
			end
			E_HOLD:
			begin
				// release the bus and answer
				d.ce_n  = 1'b1;
				d.dq_oe = 1'b0;
				d.ack   = 1'b1;
				d.st    = E_IDLE;
			end
			default:
				d.st = E_IDLE;
		endcase
	end

	// ------------------------------------------------------------------
	// registers
	// ------------------------------------------------------------------
	always_ff @(posedge sys_clk)
	begin
		if (srst)
		begin
			q      <= '0;
			q.ce_n <= fqt_pkg::STROBE_OFF;
			q.we_n <= fqt_pkg::STROBE_OFF;
			q.oe_n <= fqt_pkg::STROBE_OFF;
		end
		else
			q <= d;
	end

	assign flash_addr  = q.addr;
	assign flash_dq_o  = q.dq_o;
	assign flash_dq_oe = q.dq_oe;
	assign flash_ce_n  = q.ce_n;
	assign flash_we_n  = q.we_n;
	assign flash_oe_n  = q.oe_n;
	assign cyc.ack     = q.ack;
	assign cyc.rdata   = q.rdata;

	// ------------------------------------------------------------------
	// checks
	// ------------------------------------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (srst);

	sequence write_edge_s;
		$rose(flash_we_n) && !flash_ce_n && flash_dq_oe;
	endsequence

	write_fall_a: assert property ($fell(flash_we_n) |-> !flash_ce_n && $past(!flash_ce_n))
		else $error("write strobe fell without chip select already low");
	write_rise_a: assert property (write_edge_s |=> $rose(flash_ce_n) && flash_we_n)
		else $error("chip select did not rise one cycle after write strobe");
	read_drive_a: assert property (!flash_oe_n |-> !flash_dq_oe)
		else $error("data driven while read strobe low");

endmodule

`default_nettype wire

// ==== verilog/fqt_host.sv ====
// query-table reader: enters query mode, reads every table word, leaves
// assumes one flash on the pins, nothing else sharing the bus
`default_nettype none

module fqt_host
(
	input  wire logic        sys_clk,
	input  wire logic        srst,
	input  wire logic        start,
	input  wire logic        byte_mode,
	output logic             busy,
	output logic             done,
	output logic             pass,
	output logic [5:0]       mism_cnt,
	output logic [5:0]       first_bad,
	output logic [20:0]      flash_addr,
	output logic [15:0]      flash_dq_o,
	output logic             flash_dq_oe,
	input  wire logic [15:0] flash_dq_i,
	output logic             flash_ce_n,
	output logic             flash_we_n,
	output logic             flash_oe_n,
	output logic             flash_byte_n
);

	// ------------------------------------------------------------------
	// sequencer state
	// ------------------------------------------------------------------
	typedef enum logic [2:0]
	{
		H_IDLE  = 3'h0,
		H_ENTRY = 3'h1,
		H_READ  = 3'h3,
		H_EXIT  = 3'h2
	} fqt_seq_st_t;

	typedef struct packed
	{
		fqt_seq_st_t st;        // sequencer phase
		logic [5:0]  idx;       // table word being read
		logic        byte_md;   // mode caught at start
		logic        byte_n;    // width pin, low in byte mode, kept in its own flop
		logic        req;       // cycle request pulse
		logic        is_wr;     // request is a write
		logic [20:0] addr;      // request address
		logic [7:0]  wdata;     // request command byte
		logic        busy;      // run in progress
		logic        done;      // run finished, held until next start
		logic        pass;      // no mismatch in last run
		logic [5:0]  mism;      // mismatch count
		logic [5:0]  bad;       // first mismatching word
		logic        seen_bad;  // first_bad already caught
	} fqt_seq_t;

	fqt_seq_t q;  // registered state
	fqt_seq_t d;  // next state

	fqt_cyc_if cyc ();  // link to the cycle engine

	logic [15:0] got;   // compared read value
	logic [15:0] want;  // expected value for this word

	// ------------------------------------------------------------------
	// compare: byte mode only sees the low lines, upper byte taken as zero
	// ------------------------------------------------------------------
	always_comb
	begin
		want = fqt_pkg::fqt_expect(q.idx);
		got  = q.byte_md ? {8'h00, cyc.rdata[7:0]} : cyc.rdata;
	end

	// ------------------------------------------------------------------
	// next state
	// ------------------------------------------------------------------
	always_comb
	begin
		d     = q;
		d.req = 1'b0;
		case (q.st)
			H_IDLE:
			begin
				// entry is issued with no reset first, so a flash left in
				// identification mode goes straight to query mode too
				if (start)
				begin
					d.byte_md  = byte_mode;
					d.byte_n   = !byte_mode;
					d.busy     = 1'b1;
					d.done     = 1'b0;
					d.pass     = 1'b0;
					d.mism     = fqt_pkg::CNT_RST;
					d.bad      = fqt_pkg::CNT_RST;
					d.seen_bad = 1'b0;
					d.req      = 1'b1;
					d.is_wr    = 1'b1;
					d.wdata    = fqt_pkg::CMD_QUERY;
					d.addr     = byte_mode ? fqt_pkg::ADDR_QRY_B : fqt_pkg::ADDR_QRY_W;
					d.st       = H_ENTRY;
				end
			end
			H_ENTRY:
			begin
				// entry written: first table read
				if (cyc.ack)
				begin
					d.idx   = fqt_pkg::IDX_FIRST;
					d.req   = 1'b1;
					d.is_wr = 1'b0;
					d.addr  = fqt_pkg::fqt_map(fqt_pkg::IDX_FIRST, q.byte_md);
					d.st    = H_READ;
				end
			end
			H_READ:
			begin
				if (cyc.ack)
				begin
					// count mismatches, remember the first one
					if (got != want)
					begin
						d.mism = q.mism + 6'h01;
						if (!q.seen_bad)
						begin
							d.bad      = q.idx;
							d.seen_bad = 1'b1;
						end
					end
					d.req = 1'b1;
					if (q.idx == fqt_pkg::IDX_LAST)
					begin
						// table done: reset command back to array reads
						d.is_wr = 1'b1;
						d.wdata = fqt_pkg::CMD_RESET;
						d.addr  = fqt_pkg::ADDR_RESET;
						d.st    = H_EXIT;
					end
					else
					begin
						d.idx   = q.idx + 6'h01;
						d.is_wr = 1'b0;
						d.addr  = fqt_pkg::fqt_map(q.idx + 6'h01, q.byte_md);
					end
				end
			end
			H_EXIT:
			begin
				// flash back in array mode; results stand until next start
				if (cyc.ack)
				begin
					d.busy = 1'b0;
					d.done = 1'b1;
					d.pass = (q.mism == fqt_pkg::CNT_RST);
					d.st   = H_IDLE;
				end
			end
			default:
				d.st = H_IDLE;
		endcase
	end

	// ------------------------------------------------------------------
	// registers
	// ------------------------------------------------------------------
	always_ff @(posedge sys_clk)
	begin
		if (srst)
		begin
			q        <= '0;
			q.byte_n <= fqt_pkg::BYTE_N_RST;            // word mode until a run says otherwise
		end
		else
			q <= d;
	end

	// ------------------------------------------------------------------
	// engine hookup
	// ------------------------------------------------------------------
	assign cyc.req   = q.req;
	assign cyc.is_wr = q.is_wr;
	assign cyc.addr  = q.addr;
	assign cyc.wdata = q.wdata;

	fqt_cycle u_cycle
	(
		.sys_clk     (sys_clk),
		.srst        (srst),
		.cyc         (cyc.eng),
		.flash_addr  (flash_addr),
		.flash_dq_o  (flash_dq_o),
		.flash_dq_oe (flash_dq_oe),
		.flash_dq_i  (flash_dq_i),
		.flash_ce_n  (flash_ce_n),
		.flash_we_n  (flash_we_n),
		.flash_oe_n  (flash_oe_n)
	);

	// status outputs straight from the state flops
	assign busy         = q.busy;
	assign done         = q.done;
	assign pass         = q.pass;
	assign mism_cnt     = q.mism;
	assign first_bad    = q.bad;
	assign flash_byte_n = q.byte_n;

	// ------------------------------------------------------------------
	// checks
	// ------------------------------------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (srst);

	sequence start_idle_s;
		q.st == H_IDLE && start;
	endsequence

	sequence last_read_s;
		q.st == H_READ && cyc.ack && q.idx == fqt_pkg::IDX_LAST;
	endsequence

	entry_cmd_a: assert property (start_idle_s |=> q.req && q.is_wr && q.wdata == 8'h98
		&& q.addr == (q.byte_md ? 21'h0000AA : 21'h000055))
		else $error("query entry not issued at start");
	entry_first_a: assert property (start_idle_s |=> ##1 !q.req [*3])
		else $error("request issued before entry completed");
	upper_zero_a: assert property (q.req && !q.is_wr && !q.byte_md |-> q.addr[20:7] == 14'h0000)
		else $error("upper address bits not zero in word-mode query read");
	byte_addr_a: assert property (q.req && !q.is_wr && q.byte_md |-> q.addr == {14'h0000, q.idx, 1'b0})
		else $error("byte-mode query address not doubled");
	exit_reset_a: assert property (last_read_s |=> q.req && q.is_wr && q.wdata == 8'hF0 && q.st == H_EXIT)
		else $error("reset command not issued after last table read");
	exit_done_a: assert property (q.st == H_EXIT && cyc.ack |=> done && !busy && pass == (mism_cnt == 6'h00))
		else $error("run not closed after reset command");
	width_pin_a: assert property (flash_byte_n == !q.byte_md)
		else $error("width pin disagrees with the mode of the run");

endmodule

`default_nettype wire

// ==== tb/fqt_flash_model.sv ====
// behavioural parallel flash: array, identification and query states, table reads
// assumes host strobes change just after sys_clk edges; no clock of its own
`default_nettype none

module fqt_flash_model
#(
	parameter logic [15:0] AUTO_WORD = 16'h5A5A, // identification word, arbitrary value
	parameter logic        LOCKED    = 1'b1      // has no effect: refused writes always count as violations
)
(
	input  wire logic        force_auto,   // rising edge in array state puts part in identification state
	input  wire logic [5:0]  bad_idx,      // table word answered wrongly, 0 for none
	input  wire logic [20:0] flash_addr,
	input  wire logic [15:0] flash_dq_o,
	input  wire logic        flash_dq_oe,
	output var  logic [15:0] flash_dq_i,
	input  wire logic        flash_ce_n,
	input  wire logic        flash_we_n,
	input  wire logic        flash_oe_n,
	input  wire logic        flash_byte_n,
	output var  logic [1:0]  mode,         // 0 array, 1 identification, 2 query
	output var  int          n_entry,      // query entries accepted
	output var  int          n_reset,      // reset commands seen
	output var  int          n_viol        // bus misuse or refused writes
);
	// ------------------------------------------------------------
	// query table, words 10h..3Ch
	// ------------------------------------------------------------
	localparam logic [15:0] TBL [0:44] = '{
		16'h0051, 16'h0052, 16'h0059, 16'h0002, 16'h0000, 16'h0040,
		16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
		16'h0027, 16'h0036, 16'h0000, 16'h0000, 16'h0007, 16'h0000,
		16'h000A, 16'h0000, 16'h0001, 16'h0000, 16'h0004, 16'h0000,
		16'h0015, 16'h0002, 16'h0000, 16'h0000, 16'h0000, 16'h0004,
		16'h0000, 16'h0000, 16'h0040, 16'h0000,
		16'h0001, 16'h0000, 16'h0020, 16'h0000,
		16'h0000, 16'h0000, 16'h0080, 16'h0000,
		16'h001E, 16'h0000, 16'h0000, 16'h0001};

	logic [20:0] w_idx;   // word index of the pins
	logic        in_tbl;  // address hits a table word
	logic [15:0] val;     // value for the current address
	logic        wr_act;  // write strobe pair active
	logic [20:0] lat_a;   // latched command address

	initial
	begin
		mode    = 2'h0;   // power-up: array reads
		wr_act  = 1'b0;
		lat_a   = 21'h000000;
		n_entry = 0;
		n_reset = 0;
		n_viol  = 0;
	end

	// ------------------------------------------------------------
	// read path
	// ------------------------------------------------------------
	always_comb
	begin
		w_idx  = flash_byte_n ? flash_addr : {1'b0, flash_addr[20:1]};
		in_tbl = (w_idx >= 21'h000010) && (w_idx <= 21'h00003C) && (flash_byte_n || !flash_addr[0]);
		if (mode == 2'h2)
			val = in_tbl ? (TBL[w_idx[5:0] - 6'h10] ^ {15'h0000, w_idx[5:0] == bad_idx}) : 16'hDEAD;
		else if (mode == 2'h1)
			val = AUTO_WORD;
		else
			val = flash_addr[15:0] ^ 16'hC33C; // array pattern, never a table value at word-mode table addresses
		if (!flash_byte_n)
			val[15:8] = 8'h00;
	end

	// released lines show the inverse so a late sample cannot pass by luck
	assign flash_dq_i = (!flash_ce_n && !flash_oe_n) ? val : ~val;

	// upper address bits must be zero on query reads in word mode
	always @(negedge flash_oe_n)
	begin
		if (!flash_ce_n && mode == 2'h2 && flash_byte_n && flash_addr[20:7] != 14'h0000)
			n_viol++;
	end

	// ------------------------------------------------------------
	// write decode: address at later fall, data at earlier rise
	// ------------------------------------------------------------
	always @(flash_ce_n or flash_we_n or posedge force_auto)
	begin
		if (force_auto && mode == 2'h0)
			mode = 2'h1;
		if (!wr_act && !flash_ce_n && !flash_we_n && flash_oe_n)
		begin
			wr_act = 1'b1;
			lat_a  = flash_addr;
		end
		else if (wr_act && (flash_ce_n || flash_we_n))
		begin
			wr_act = 1'b0;
			do_cmd(lat_a, flash_dq_oe ? flash_dq_o[7:0] : 8'h00);
		end
	end

	task automatic do_cmd(input logic [20:0] a, input logic [7:0] d);
		logic [20:0] qa;
		qa = flash_byte_n ? fqt_pkg::ADDR_QRY_W : fqt_pkg::ADDR_QRY_B;
		if (d == fqt_pkg::CMD_RESET)
		begin
			mode = 2'h0;
			n_reset++;
		end
		else if (d == fqt_pkg::CMD_QUERY && a == qa && mode != 2'h2)
		begin
			mode = 2'h2;
			n_entry++;
		end
		else if (d == fqt_pkg::CMD_QUERY && mode == 2'h2)
			mode = 2'h2;
		else if (LOCKED || 1'b1)
			n_viol++; // nothing else may alter the part
	endtask
endmodule

`default_nettype wire

// ==== tb/tb_fqt_host.sv ====
// self-checking bench for the query-table reader against a flash model
// assumes the package and design files are compiled first
`default_nettype none

module tb_fqt_host;
	timeunit 1ns;
	timeprecision 1ns;

	// ------------------------------------------------------------
	// signals
	// ------------------------------------------------------------
	logic        sys_clk = 1'b0;
	logic        srst, start, byte_mode, force_auto;
	logic [5:0]  bad_idx;
	logic        busy, done, pass, flash_dq_oe, flash_ce_n, flash_we_n, flash_oe_n, flash_byte_n;
	logic [5:0]  mism_cnt, first_bad;
	logic [20:0] flash_addr;
	logic [15:0] flash_dq_o, flash_dq_i;
	logic [1:0]  mode;
	int          n_entry, n_reset, n_viol;
	int          n_fail = 0;
	int          comparisons = 0;
	int          cyc = 0;

	always #50 sys_clk = ~sys_clk; // 10 MHz

	fqt_host dut (.sys_clk(sys_clk), .srst(srst), .start(start), .byte_mode(byte_mode), .busy(busy),
		.done(done), .pass(pass), .mism_cnt(mism_cnt), .first_bad(first_bad), .flash_addr(flash_addr),
		.flash_dq_o(flash_dq_o), .flash_dq_oe(flash_dq_oe), .flash_dq_i(flash_dq_i), .flash_ce_n(flash_ce_n),
		.flash_we_n(flash_we_n), .flash_oe_n(flash_oe_n), .flash_byte_n(flash_byte_n));

	fqt_flash_model flash (.force_auto(force_auto), .bad_idx(bad_idx), .flash_addr(flash_addr),
		.flash_dq_o(flash_dq_o), .flash_dq_oe(flash_dq_oe), .flash_dq_i(flash_dq_i), .flash_ce_n(flash_ce_n),
		.flash_we_n(flash_we_n), .flash_oe_n(flash_oe_n), .flash_byte_n(flash_byte_n), .mode(mode),
		.n_entry(n_entry), .n_reset(n_reset), .n_viol(n_viol));

	// ------------------------------------------------------------
	// compare and closing tasks
	// ------------------------------------------------------------
	task automatic chk_flag(input string what, input logic exp, input logic got);
		comparisons++;
		if (got !== exp)
		begin
			n_fail++;
			$display("BAD %s expected %b seen %b", what, exp, got);
		end
	endtask

	task automatic chk_num(input string what, input logic [20:0] exp, input logic [20:0] got);
		comparisons++;
		if (got !== exp)
		begin
			n_fail++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// hang guard: a full run is some 460 cycles
	always @(posedge sys_clk)
	begin
		cyc++;
		if (cyc == 30000)
		begin
			n_fail++;
			report_and_stop();
		end
	end

	// ------------------------------------------------------------
	// one run: start, optional second start while busy, judge
	// ------------------------------------------------------------
	task automatic run_check(input logic bm, input logic poke, input int d_entry, input logic p,
		input logic [5:0] nbad, input logic [5:0] fb);
		int k;
		int e0;
		int r0;
		e0 = n_entry;
		r0 = n_reset;
		@(negedge sys_clk);
		start = 1'b1;
		byte_mode = bm;
		@(negedge sys_clk);
		start = 1'b0;
		@(negedge sys_clk);
		chk_flag("busy", 1'b1, busy);
		chk_flag("done", 1'b0, done);
		chk_flag("byte_n", !bm, flash_byte_n);
		k = 0;
		while (done !== 1'b1 && k < 3000)
		begin
			@(negedge sys_clk);
			k++;
			start = poke && (k == 60); // ignored while busy
		end
		chk_flag("done", 1'b1, done);
		chk_flag("busy", 1'b0, busy);
		chk_flag("pass", p, pass);
		chk_num("mism_cnt", {15'h0000, nbad}, {15'h0000, mism_cnt});
		chk_num("first_bad", {15'h0000, fb}, {15'h0000, first_bad});
		chk_num("mode", 21'h000000, {19'h00000, mode});
		chk_num("entries", 21'(d_entry), 21'(n_entry - e0));
		chk_num("resets", 21'h000001, 21'(n_reset - r0));
		chk_num("violations", 21'h000000, 21'(n_viol));
	endtask

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_word();
		run_check(1'b0, 1'b1, 1, 1'b1, 6'h00, 6'h00);
	endtask

	task automatic t_byte();
		run_check(1'b1, 1'b0, 1, 1'b1, 6'h00, 6'h00);
	endtask

	task automatic t_auto();
		@(negedge sys_clk);
		force_auto = 1'b1;
		@(negedge sys_clk);
		force_auto = 1'b0;
		chk_num("mode", 21'h000001, {19'h00000, mode});
		run_check(1'b0, 1'b0, 1, 1'b1, 6'h00, 6'h00);
	endtask

	task automatic t_bad();
		bad_idx = 6'h3C;
		run_check(1'b0, 1'b0, 1, 1'b0, 6'h01, 6'h3C);
		bad_idx = 6'h10;
		run_check(1'b1, 1'b0, 1, 1'b0, 6'h01, 6'h10);
		bad_idx = 6'h00;
	endtask

	// reset in mid-run leaves the part in query state; the rerun's entry is ignored
	task automatic t_mid_reset();
		@(negedge sys_clk);
		start = 1'b1;
		byte_mode = 1'b0;
		@(negedge sys_clk);
		start = 1'b0;
		repeat (150) @(negedge sys_clk);
		srst = 1'b1;
		repeat (2) @(negedge sys_clk);
		chk_flag("busy", 1'b0, busy);
		chk_flag("done", 1'b0, done);
		chk_flag("ce_n", 1'b1, flash_ce_n);
		chk_flag("we_n", 1'b1, flash_we_n);
		chk_flag("oe_n", 1'b1, flash_oe_n);
		chk_flag("dq_oe", 1'b0, flash_dq_oe);
		chk_num("mode", 21'h000002, {19'h00000, mode});
		srst = 1'b0;
		run_check(1'b0, 1'b0, 0, 1'b1, 6'h00, 6'h00);
	endtask

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial
	begin
		srst = 1'b1;
		start = 1'b0;
		byte_mode = 1'b0;
		force_auto = 1'b0;
		bad_idx = 6'h00;
		repeat (8) @(negedge sys_clk);
		srst = 1'b0;
		t_word();
		t_byte();
		t_auto();
		t_bad();
		t_mid_reset();
		report_and_stop();
	end
endmodule

`default_nettype wire
